// ==== logic/isu_pkg.sv ====
// shared constants, types and helpers for the isolated serial port
`default_nettype none
package isu_pkg;
   // reference clock synthesis from the system clock
   localparam longint unsigned SYS_CLK_HZ  = 64'd25_000_000;
   localparam longint unsigned REF_SLOW_HZ = 64'd1_843_200;
   localparam longint unsigned REF_FAST_HZ = 64'd7_372_800;
   localparam int              ACC_W       = 24;
   localparam logic [23:0] INC_SLOW = 24'((REF_SLOW_HZ << ACC_W) / SYS_CLK_HZ);
   localparam logic [23:0] INC_FAST = 24'((REF_FAST_HZ << ACC_W) / SYS_CLK_HZ);

   // sixteen oversample ticks per bit; mid sample and last tick of a bit
   localparam logic [3:0] OS_MID  = 4'h7;
   localparam logic [3:0] OS_LAST = 4'hf;

   // register offsets on address lines 2..0
   localparam logic [2:0] OFS_DATA   = 3'h0;
   localparam logic [2:0] OFS_DIV_HI = 3'h1;
   localparam logic [2:0] OFS_IDENT  = 3'h2;
   localparam logic [2:0] OFS_FMT    = 3'h3;
   localparam logic [2:0] OFS_MODEM  = 3'h4;
   localparam logic [2:0] OFS_LSTAT  = 3'h5;

   // field positions
   localparam int FMT_DIVSEL_BIT     = 7;
   localparam int MODEM_RTS_BIT      = 1;
   localparam int MODEM_OUT1_BIT     = 2;
   localparam int MODEM_IRQ_GATE_BIT = 3;

   // interrupt source codes
   localparam logic [7:0] IDENT_RX_AVAIL = 8'h04;
   localparam logic [7:0] IDENT_NONE     = 8'h01;

   // reset values
   localparam logic [7:0]  FMT_RST   = 8'h00;
   localparam logic [7:0]  MODEM_RST = 8'h00;
   localparam logic [15:0] DIV_RST   = 16'h000c;

   localparam int FIFO_DEPTH = 8;

   // line format fields, same order as bits 6..0 of the format register
   typedef struct packed {
      logic       brk;
      logic       stick;
      logic       even;
      logic       par_en;
      logic       two_stop;
      logic [1:0] len;
   } isu_frame_t;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'h0,
      RX_START = 3'h1,
      RX_DATA  = 3'h3,
      RX_PAR   = 3'h2,
      RX_STOP  = 3'h6
   } isu_rx_state_t;

   function automatic logic [3:0] isu_data_bits(input isu_frame_t f);
      isu_data_bits = 4'h5 + {2'b00, f.len};
   endfunction : isu_data_bits

   function automatic logic isu_parity(input logic [7:0] d,
                                       input isu_frame_t f);
      logic [7:0] m;
      m = d & (8'hff >> (4'h3 - {2'b00, f.len}));
      if (f.stick)
         isu_parity = ~f.even;
      else
         isu_parity = f.even ? ^m : ~^m;
   endfunction : isu_parity
endpackage : isu_pkg
`default_nettype wire

// ==== logic/isu_fifo.sv ====
// small first-word-fall-through queue with registered read data
`timescale 1ns/1ps
`default_nettype none
module isu_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         sys_rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data,
   output logic              empty
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          load;

   // depth must be a power of two; pointers simply wrap
   assign in_ready = cnt_q != (AW+1)'(DEPTH);
   assign push     = in_valid && in_ready;
   assign load     = (cnt_q != '0) && (!out_valid || out_ready);
   assign empty    = (cnt_q == '0) && !out_valid;

   always_ff @(posedge clk_sys) begin
      if (push)
         mem[wp_q] <= in_data;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wp_q      <= '0;
         rp_q      <= '0;
         cnt_q     <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         wp_q  <= push ? wp_q + 1'b1 : wp_q;
         rp_q  <= load ? rp_q + 1'b1 : rp_q;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
         if (load) begin
            out_valid <= 1'b1;
            out_data  <= mem[rp_q];
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule : isu_fifo
`default_nettype wire

// ==== logic/isu_tx.sv ====
// character serializer: start, data lsb first, parity, stop bits
`timescale 1ns/1ps
`default_nettype none
module isu_tx
   import isu_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       os_tick,
   input  wire isu_frame_t frame,
   input  wire logic       in_valid,
   output logic            in_ready,
   input  wire logic [7:0] in_data,
   output logic            txd_q,
   output logic            busy_q
);
   logic [11:0] shift_q;
   logic [3:0]  bits_q;
   logic [3:0]  os_q;
   logic [11:0] build;
   logic [3:0]  nbits;
   logic [3:0]  ndata;
   logic        last_tick;

   // loads land on a tick so the start bit is a full bit long,
   // and a queued byte follows the last stop bit with no gap
   assign last_tick = busy_q && os_q == OS_LAST && bits_q == 4'h1;
   assign in_ready  = os_tick && (!busy_q || last_tick);
   assign ndata    = isu_data_bits(frame);

   always_comb begin
      build = '1;
      build[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < ndata)
            build[i+1] = in_data[i];
      end
      if (frame.par_en)
         build[ndata+4'h1] = isu_parity(in_data, frame);
      nbits = 4'h1 + ndata + {3'b000, frame.par_en}
            + (frame.two_stop ? 4'h2 : 4'h1);
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         shift_q <= '1;
         bits_q  <= '0;
         os_q    <= '0;
         busy_q  <= 1'b0;
         txd_q   <= 1'b1;
      end else begin
         if (in_valid && in_ready) begin
            shift_q <= build;
            bits_q  <= nbits;
            os_q    <= '0;
            busy_q  <= 1'b1;
         end else if (busy_q && os_tick) begin
            os_q <= os_q + 1'b1;
            if (os_q == OS_LAST) begin
               shift_q <= {1'b1, shift_q[11:1]};
               bits_q  <= bits_q - 1'b1;
               busy_q  <= bits_q != 4'h1;
            end
         end
         // break holds the line low regardless of queued data
         txd_q <= frame.brk ? 1'b0 : (busy_q ? shift_q[0] : 1'b1);
      end
   end
endmodule : isu_tx
`default_nettype wire

// ==== logic/isu_uart_port.sv ====
// byte-wide serial port with register set, queues and driver control
`timescale 1ns/1ps
`default_nettype none
module isu_uart_port
   import isu_pkg::*;
#(
   parameter int FIFO_W = 8,
   parameter int FIFO_D = FIFO_DEPTH
) (
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic [2:0] io_addr,
   input  wire logic [7:0] io_wdata,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   output logic [7:0]      io_rdata,
   input  wire logic       fast_clock_range,
   input  wire logic       two_wire_mode,
   input  wire logic       line_rx_in,
   output logic            line_tx_out,
   output logic            line_tx_oe,
   output logic            rts_out,
   output logic            user_out1,
   output logic            host_irq
);
   // pin synchronisers, second stage only is read
   logic [1:0] rx_s_q;
   logic [1:0] fast_s_q;
   logic [1:0] two_s_q;

   logic [7:0]  fmt_q;
   logic [7:0]  modem_q;
   logic [15:0] div_q;
   logic        overrun_q;
   logic        parity_err_q;
   logic        framing_err_q;
   logic        break_q;

   logic [ACC_W-1:0] acc_q;
   logic [ACC_W:0]   acc_sum;
   logic [ACC_W-1:0] acc_inc;
   logic             ref_tick_q;
   logic [15:0]      div_cnt_q;
   logic             os_tick_q;

   isu_rx_state_t rx_state_q;
   logic [3:0]    rx_os_q;
   logic [3:0]    rx_bit_q;
   logic [7:0]    rx_shift_q;
   logic          rx_par_q;

   isu_frame_t  frame;
   logic        divsel;
   logic        rxd;
   logic        two_wire;
   logic [3:0]  ndata;
   logic        wr_div_lo;
   logic        wr_div_hi;
   logic        wr_fmt;
   logic        wr_modem;
   logic        wr_tx;
   logic        rd_rx;
   logic        rd_ls;
   logic        tx_room;
   logic        tx_valid;
   logic        tx_ready;
   logic [7:0]  tx_byte;
   logic        tx_empty;
   logic        tx_busy;
   logic        txd;
   logic        rx_push;
   logic        rx_room;
   logic        rx_avail;
   logic [7:0]  rx_byte;
   logic [7:0]  rx_head;
   logic        rx_pe;
   logic        rx_fe;
   logic        rx_brk;
   logic        os_last;
   logic [7:0]  ident;
   logic [7:0]  lstat;
   logic [7:0]  rd_word;

   assign frame    = isu_frame_t'(fmt_q[6:0]);
   assign divsel   = fmt_q[FMT_DIVSEL_BIT];
   assign rxd      = rx_s_q[1];
   assign two_wire = two_s_q[1];
   assign ndata    = isu_data_bits(frame);

   // host access decode
   assign wr_div_lo = io_wr && io_addr == OFS_DATA && divsel;
   assign wr_div_hi = io_wr && io_addr == OFS_DIV_HI && divsel;
   assign wr_fmt    = io_wr && io_addr == OFS_FMT;
   assign wr_modem  = io_wr && io_addr == OFS_MODEM;
   // data writes under divisor access never reach the queue
   assign wr_tx     = io_wr && io_addr == OFS_DATA && !divsel;
   assign rd_rx     = io_rd && io_addr == OFS_DATA && !divsel;
   assign rd_ls     = io_rd && io_addr == OFS_LSTAT;

   // reference clock by phase accumulator, jitter under one system clock
   assign acc_inc = fast_s_q[1] ? INC_FAST : INC_SLOW;
   assign acc_sum = {1'b0, acc_q} + {1'b0, acc_inc};

   // receive framing
   assign os_last = os_tick_q && rx_os_q == OS_LAST;
   assign rx_push = rx_state_q == RX_STOP && os_last;
   assign rx_byte = rx_shift_q >> (4'h8 - ndata);
   assign rx_pe   = frame.par_en
                    && rx_par_q != isu_parity(rx_byte, frame);
   assign rx_fe   = !rxd;
   assign rx_brk  = rx_fe && rx_byte == 8'h00 && !rx_par_q;

   // read side
   assign ident = rx_avail ? IDENT_RX_AVAIL : IDENT_NONE;
   assign lstat = {1'b0, tx_empty && !tx_busy, tx_empty, break_q,
                   framing_err_q, parity_err_q, overrun_q,
                   rx_avail};
   assign rd_word =
      (io_addr == OFS_DATA)   ? (divsel ? div_q[7:0] : rx_head) :
      (io_addr == OFS_DIV_HI) ? (divsel ? div_q[15:8] : 8'h00) :
      (io_addr == OFS_IDENT)  ? ident :
      (io_addr == OFS_FMT)    ? fmt_q :
      (io_addr == OFS_MODEM)  ? modem_q :
      (io_addr == OFS_LSTAT)  ? lstat : 8'h00;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rx_s_q   <= 2'b11;
         fast_s_q <= 2'b00;
         two_s_q  <= 2'b00;
      end else begin
         rx_s_q   <= {rx_s_q[0], line_rx_in};
         fast_s_q <= {fast_s_q[0], fast_clock_range};
         two_s_q  <= {two_s_q[0], two_wire_mode};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         fmt_q   <= FMT_RST;
         modem_q <= MODEM_RST;
         div_q   <= DIV_RST;
      end else begin
         if (wr_fmt)
            fmt_q <= io_wdata;
         if (wr_modem)
            modem_q <= io_wdata;
         if (wr_div_lo)
            div_q[7:0] <= io_wdata;
         if (wr_div_hi)
            div_q[15:8] <= io_wdata;
      end
   end

   // sticky line errors; a new event wins over the clearing read
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         overrun_q     <= 1'b0;
         parity_err_q  <= 1'b0;
         framing_err_q <= 1'b0;
         break_q       <= 1'b0;
      end else begin
         overrun_q     <= (overrun_q && !rd_ls) || (rx_push && !rx_room);
         parity_err_q  <= (parity_err_q && !rd_ls) || (rx_push && rx_pe);
         framing_err_q <= (framing_err_q && !rd_ls) || (rx_push && rx_fe);
         break_q       <= (break_q && !rd_ls) || (rx_push && rx_brk);
      end
   end

   // divisor 0 counts as 65536
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         acc_q      <= '0;
         ref_tick_q <= 1'b0;
         div_cnt_q  <= '0;
         os_tick_q  <= 1'b0;
      end else begin
         acc_q      <= acc_sum[ACC_W-1:0];
         ref_tick_q <= acc_sum[ACC_W];
         os_tick_q  <= ref_tick_q && div_cnt_q == '0;
         if (ref_tick_q)
            div_cnt_q <= (div_cnt_q == '0) ? div_q - 1'b1
                                           : div_cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rx_state_q <= RX_IDLE;
         rx_os_q    <= '0;
         rx_bit_q   <= '0;
         rx_shift_q <= '0;
         rx_par_q   <= 1'b0;
      end else if (os_tick_q) begin
         rx_os_q <= rx_os_q + 1'b1;
         unique case (rx_state_q)
            RX_IDLE: begin
               rx_os_q <= '0;
               if (!rxd)
                  rx_state_q <= RX_START;
            end
            RX_START: begin
               // a start bit gone at mid bit was noise
               if (rx_os_q == OS_MID) begin
                  rx_os_q    <= '0;
                  rx_bit_q   <= '0;
                  rx_par_q   <= 1'b0;
                  rx_state_q <= rxd ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_os_q == OS_LAST) begin
                  rx_shift_q <= {rxd, rx_shift_q[7:1]};
                  rx_bit_q   <= rx_bit_q + 1'b1;
                  if (rx_bit_q == ndata - 4'h1)
                     rx_state_q <= frame.par_en ? RX_PAR : RX_STOP;
               end
            end
            RX_PAR: begin
               if (rx_os_q == OS_LAST) begin
                  rx_par_q   <= rxd;
                  rx_state_q <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_os_q == OS_LAST)
                  rx_state_q <= RX_IDLE;
            end
            default: rx_state_q <= RX_IDLE;
         endcase
      end
   end

   // outputs, all registered
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         io_rdata   <= 8'h00;
         rts_out    <= 1'b0;
         user_out1  <= 1'b0;
         host_irq   <= 1'b0;
         line_tx_oe <= 1'b0;
      end else begin
         if (io_rd)
            io_rdata <= rd_word;
         rts_out   <= modem_q[MODEM_RTS_BIT];
         user_out1 <= modem_q[MODEM_OUT1_BIT];
         host_irq  <= modem_q[MODEM_IRQ_GATE_BIT] && rx_avail;
         // four-wire drivers are tristated only during reset
         line_tx_oe <= two_wire ? (tx_busy || !tx_empty)
                                : 1'b1;
      end
   end

   assign line_tx_out = txd;

   // writes to a full transmit queue are dropped
   isu_fifo #(
      .W     (FIFO_W),
      .DEPTH (FIFO_D)
   ) u_tx_fifo (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .in_valid  (wr_tx),
      .in_ready  (tx_room),
      .in_data   (io_wdata),
      .out_valid (tx_valid),
      .out_ready (tx_ready),
      .out_data  (tx_byte),
      .empty     (tx_empty)
   );

   isu_tx u_tx (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .os_tick  (os_tick_q),
      .frame    (frame),
      .in_valid (tx_valid),
      .in_ready (tx_ready),
      .in_data  (tx_byte),
      .txd_q    (txd),
      .busy_q   (tx_busy)
   );

   isu_fifo #(
      .W     (FIFO_W),
      .DEPTH (FIFO_D)
   ) u_rx_fifo (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .in_valid  (rx_push),
      .in_ready  (rx_room),
      .in_data   (rx_byte),
      .out_valid (rx_avail),
      .out_ready (rd_rx),
      .out_data  (rx_head),
      .empty     ()
   );
endmodule : isu_uart_port
`default_nettype wire

// ==== tb/isu_uart_port_asserts.sv ====
// pin-level checks for the serial port, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module isu_uart_port_asserts
   import isu_pkg::*;
#(
   parameter int FIFO_W = 8,
   parameter int FIFO_D = 8
) (
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic [2:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic       io_wr,
   input wire logic       io_rd,
   input wire logic [7:0] io_rdata,
   input wire logic       fast_clock_range,
   input wire logic       two_wire_mode,
   input wire logic       line_rx_in,
   input wire logic       line_tx_out,
   input wire logic       line_tx_oe,
   input wire logic       rts_out,
   input wire logic       user_out1,
   input wire logic       host_irq
);
   // shadow copies, the design's own registers are not visible here
   logic [7:0]  fmt_q;
   logic [7:0]  mdm_q;
   logic [15:0] div_q;
   wire logic   divsel = fmt_q[FMT_DIVSEL_BIT];
   wire logic   adr0 = io_addr[0];
   wire logic   wr_div = io_wr && divsel && io_addr[2:1] == 2'b00;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         fmt_q <= FMT_RST;
         mdm_q <= MODEM_RST;
         div_q <= DIV_RST;
      end else begin
         if (io_wr && io_addr == OFS_FMT)
            fmt_q <= io_wdata;
         if (io_wr && io_addr == OFS_MODEM)
            mdm_q <= io_wdata;
         if (wr_div && !adr0)
            div_q[7:0] <= io_wdata;
         if (wr_div && adr0)
            div_q[15:8] <= io_wdata;
      end
   end
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   chk_div_read: assert property (
      io_rd && divsel && io_addr[2:1] == 2'b00 |=>
      io_rdata == ($past(adr0) ? div_q[15:8] : div_q[7:0]))
      else $error("divisor readback wrong");
   chk_fmt_read: assert property (
      io_rd && io_addr == OFS_FMT |=> io_rdata == fmt_q)
      else $error("format readback wrong");
   chk_unmapped_zero: assert property (
      io_rd && (io_addr[2:1] == 2'b11 || io_addr == OFS_DIV_HI && !divsel)
      |=> io_rdata == 8'h00) else $error("unmapped read not zero");
   chk_ident_code: assert property (
      io_rd && io_addr == OFS_IDENT |=>
      io_rdata == IDENT_RX_AVAIL || io_rdata == IDENT_NONE)
      else $error("identification code unknown");
   chk_rdata_hold: assert property (
      !io_rd |=> $stable(io_rdata)) else $error("read data moved");
   chk_modem_pins: assert property (
      $stable(mdm_q) [*2] |->
      rts_out == mdm_q[MODEM_RTS_BIT] && user_out1 == mdm_q[MODEM_OUT1_BIT])
      else $error("modem outputs differ from modem control");
   chk_irq_gate: assert property (
      !mdm_q[MODEM_IRQ_GATE_BIT] [*3] |-> !host_irq)
      else $error("interrupt passed a closed gate");
   chk_four_wire_on: assert property (
      !two_wire_mode [*6] |-> line_tx_oe)
      else $error("four-wire driver not enabled");
   chk_zero_driven: assert property (
      two_wire_mode && !line_tx_out |-> line_tx_oe)
      else $error("data bit sent with driver off");
   chk_oe_hold: assert property (
      line_tx_oe && !line_tx_out |=> line_tx_oe)
      else $error("driver released during a frame");
   chk_write_oe: assert property (
      two_wire_mode && io_wr && io_addr == OFS_DATA && !divsel
      |-> ##[1:3] line_tx_oe) else $error("driver late after data write");
endmodule : isu_uart_port_asserts
bind isu_uart_port isu_uart_port_asserts #(.FIFO_W(FIFO_W), .FIFO_D(FIFO_D))
   u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .io_addr(io_addr),
   .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
   .fast_clock_range(fast_clock_range), .two_wire_mode(two_wire_mode),
   .line_rx_in(line_rx_in), .line_tx_out(line_tx_out),
   .line_tx_oe(line_tx_oe), .rts_out(rts_out), .user_out1(user_out1),
   .host_irq(host_irq));
`default_nettype wire

// ==== tb/isu_line_node.sv ====
// remote node on the pair: listens to the port and sends bytes to it
`timescale 1ns/1ps
`default_nettype none
module isu_line_node (
   input  wire logic line_tx_out,
   input  wire logic line_tx_oe,
   output logic      line_rx_in
);
   realtime    bit_ns = 1.0e9 / 460800.0;
   logic [7:0] got_q[$];
   logic [8:0] b;
   // bit after the data: parity on framed characters
   logic       ninth;
   // a released pair is biased to the idle mark level
   wire logic  seen = line_tx_oe ? line_tx_out : 1'b1;
   initial line_rx_in = 1'b1;
   always begin
      @(negedge seen);
      #(bit_ns * 1.5);
      for (int i = 0; i < 9; i++) begin
         b[i] = seen;
         #(bit_ns);
      end
      ninth = b[8];
      got_q.push_back(b[7:0]);
   end
   // gap in bit times after the stop bit: zero is a prompt sender
   task automatic send(input logic [7:0] d, input int gap);
      line_rx_in = 1'b0;
      #(bit_ns);
      for (int i = 0; i < 8; i++) begin
         line_rx_in = d[i];
         #(bit_ns);
      end
      line_rx_in = 1'b1;
      #(bit_ns * (1 + gap));
   endtask : send
endmodule : isu_line_node
`default_nettype wire

// ==== tb/isu_uart_port_bench.sv ====
// self-checking bench for the serial port registers and line
`timescale 1ns/1ps
`default_nettype none
module isu_uart_port_bench
   import isu_pkg::*;
();
   localparam longint unsigned BAUD_FAST = 64'h0007_0800;
   localparam longint unsigned BAUD_SLOW = 64'h0001_c200;
   logic       clk_sys, sys_rst, io_wr, io_rd, fast_clock_range;
   logic       two_wire_mode, line_rx_in, line_tx_out, line_tx_oe;
   logic       rts_out, user_out1, host_irq;
   logic [2:0] io_addr;
   logic [7:0] io_wdata, io_rdata;
   int         n_errors = 0;
   int         checked = 0;
   isu_uart_port dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
      .io_rdata(io_rdata), .fast_clock_range(fast_clock_range),
      .two_wire_mode(two_wire_mode), .line_rx_in(line_rx_in),
      .line_tx_out(line_tx_out), .line_tx_oe(line_tx_oe),
      .rts_out(rts_out), .user_out1(user_out1), .host_irq(host_irq));
   isu_line_node node (.line_tx_out(line_tx_out), .line_tx_oe(line_tx_oe),
      .line_rx_in(line_rx_in));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic chk(input string what, input logic [7:0] exp, got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chk_near(input string what, input int exp, got);
      checked++;
      if (got < exp - 3 || got > exp + 3) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_near
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk_sys);
      io_wr = 1'b0;
   endtask : wr
   task automatic rc(input logic [2:0] a, input logic [7:0] exp,
                     input string what);
      @(negedge clk_sys);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk_sys);
      io_rd = 1'b0;
      @(negedge clk_sys);
      chk(what, exp, io_rdata);
   endtask : rc
   // one character; start bit to driver release proves the bit rate
   task automatic tx_one(input logic [7:0] f, d, e, input int bits);
      int n, want;
      want = int'(64'(bits) * SYS_CLK_HZ /
                  (fast_clock_range ? BAUD_FAST : BAUD_SLOW));
      n = 0;
      wr(OFS_FMT, f);
      wr(OFS_DATA, d);
      while (line_tx_out && n < 99) begin
         @(negedge clk_sys);
         n++;
      end
      chk("start bit", 8'h00, {7'h00, line_tx_out});
      n = 0;
      while (line_tx_oe && n < 9999) begin
         @(negedge clk_sys);
         n++;
      end
      chk_near("driver span", want, n);
      // the listener samples past a short frame, let it finish
      n = 0;
      while (node.got_q.size() == 0 && n < 9999) begin
         @(negedge clk_sys);
         n++;
      end
      chk("tx byte", e, node.got_q.pop_front());
   endtask : tx_one
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize
   initial begin
      repeat (60000) @(posedge clk_sys);
      n_errors++;
      summarize();
   end
   initial begin
      sys_rst = 1'b1;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_addr = 3'h0;
      io_wdata = 8'h00;
      fast_clock_range = 1'b1;
      two_wire_mode = 1'b0;
      repeat (20) @(negedge clk_sys);
      sys_rst = 1'b0;
      rc(OFS_FMT, FMT_RST, "format reset");
      rc(OFS_MODEM, MODEM_RST, "modem reset");
      rc(OFS_IDENT, IDENT_NONE, "ident reset");
      rc(OFS_LSTAT, 8'h60, "status reset");
      wr(3'h7, 8'hff);
      wr(OFS_DIV_HI, 8'hff);
      rc(OFS_DIV_HI, 8'h00, "offset 1 plain");
      rc(3'h6, 8'h00, "offset 6");
      rc(3'h7, 8'h00, "offset 7");
      chk("four-wire driver", 8'h01, {7'h00, line_tx_oe});
      $display("test reset done");
      wr(OFS_FMT, 8'h80);
      rc(OFS_DATA, DIV_RST[7:0], "div low reset");
      rc(OFS_DIV_HI, DIV_RST[15:8], "div high reset");
      wr(OFS_DATA, 8'h01);
      wr(OFS_DIV_HI, 8'h00);
      rc(OFS_DATA, 8'h01, "div low");
      rc(OFS_DIV_HI, 8'h00, "div high");
      wr(OFS_FMT, 8'h03);
      $display("test divisor done");
      wr(OFS_MODEM, 8'h06);
      repeat (4) @(negedge clk_sys);
      chk("rts on", 8'h01, {7'h00, rts_out});
      chk("out1 on", 8'h01, {7'h00, user_out1});
      wr(OFS_MODEM, 8'h02);
      two_wire_mode = 1'b1;
      repeat (8) @(negedge clk_sys);
      chk("out1 off", 8'h00, {7'h00, user_out1});
      chk("rts alone", 8'h00, {7'h00, line_tx_oe});
      $display("test modem done");
      tx_one(8'h03, 8'ha5, 8'ha5, 10);
      tx_one(8'h00, 8'h00, 8'he0, 7);
      tx_one(8'h07, 8'h3c, 8'h3c, 11);
      tx_one(8'h0b, 8'h01, 8'h01, 11);
      chk("odd parity", 8'h00, {7'h00, node.ninth});
      tx_one(8'h1b, 8'h01, 8'h01, 11);
      chk("even parity", 8'h01, {7'h00, node.ninth});
      fast_clock_range = 1'b0;
      node.bit_ns = 1.0e9 / 115200.0;
      repeat (8) @(negedge clk_sys);
      tx_one(8'h03, 8'hc3, 8'hc3, 10);
      fast_clock_range = 1'b1;
      node.bit_ns = 1.0e9 / 460800.0;
      $display("test transmit done");
      wr(OFS_MODEM, 8'h08);
      node.send(8'h3c, 0);
      node.send(8'h96, 2);
      rc(OFS_LSTAT, 8'h61, "rx ready");
      rc(OFS_IDENT, IDENT_RX_AVAIL, "ident rx");
      chk("irq on", 8'h01, {7'h00, host_irq});
      rc(OFS_DATA, 8'h3c, "rx first");
      rc(OFS_DATA, 8'h96, "rx second");
      rc(OFS_IDENT, IDENT_NONE, "ident idle");
      chk("irq off", 8'h00, {7'h00, host_irq});
      rc(OFS_LSTAT, 8'h60, "rx empty");
      wr(OFS_MODEM, 8'h00);
      node.send(8'h55, 0);
      chk("irq gated", 8'h00, {7'h00, host_irq});
      rc(OFS_DATA, 8'h55, "flush first");
      wr(OFS_FMT, 8'h03);
      rc(OFS_LSTAT, 8'h60, "flushed");
      $display("test receive done");
      summarize();
   end
endmodule : isu_uart_port_bench
`default_nettype wire
